/* File: src/fdt_pkg.sv */
// constants and types for the fast decrementing timer
package fdt_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TEN_MS_US = 10_000;
  localparam int unsigned ONE_MS_US = 1_000;
  localparam int unsigned TEN_MS_CYC = TEN_MS_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ONE_MS_CYC = ONE_MS_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TIMER_W = 16;
  localparam int unsigned NUM_TEN = 256;
  localparam int unsigned NUM_ONE = 16;
  localparam logic [15:0] CLR_BCD = 16'h9999;
  localparam logic [15:0] CLR_BIN = 16'hffff;
  localparam logic [15:0] ZERO_CNT = 16'h0000;
  localparam int unsigned HOLD_BIT = 12;
  typedef enum logic [1:0] {
    RES_TEN = 2'b00,
    RES_ONE = 2'b01
  } res_t;
endpackage

/* File: src/fdt_tick.sv */
// one-cycle tick divider
`timescale 1ns/1ps
`default_nettype none
module fdt_tick #(
  parameter int unsigned PERIOD = 1000
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);
  logic [31:0] cnt_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_ff == 32'(PERIOD - 1)) begin
      cnt_ff <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // fdt_tick
`default_nettype wire

/* File: src/fast_decrementing_timer.sv */
// decrementing on-delay timer bank, ten-ms and one-ms resolutions
`timescale 1ns/1ps
`default_nettype none
module fast_decrementing_timer
  import fdt_pkg::*;
#(
  parameter int unsigned TEN_PERIOD = fdt_pkg::TEN_MS_CYC,
  parameter int unsigned ONE_PERIOD = fdt_pkg::ONE_MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // instruction execution
  input wire logic exec,
  input wire fdt_pkg::res_t res,
  input wire logic bcd_mode,
  input wire logic [7:0] timer_num,
  input wire logic timer_in,
  input wire logic [15:0] preset_value,
  // region and control
  input wire logic interlocked,
  input wire logic jumped,
  input wire logic task_standby,
  input wire logic force_set,
  input wire logic force_reset,
  input wire logic clear_timer_op,
  input wire logic mode_change,
  input wire logic [15:0] aux_word,
  // present count write (move_word)
  input wire logic pv_write,
  input wire logic [15:0] pv_wdata,
  // results
  output logic [15:0] present_count,
  output logic done,
  output logic bad_bcd_flag
);
  import fdt_pkg::*;

  // ==========================================================
  // time-unit ticks, counted per running timer until its next execution
  // ==========================================================
  logic tick_ten;
  logic tick_one;
  fdt_tick #(.PERIOD(TEN_PERIOD)) u_ten (.clk(clk), .resetn(resetn), .tick(tick_ten));
  fdt_tick #(.PERIOD(ONE_PERIOD)) u_one (.clk(clk), .resetn(resetn), .tick(tick_one));

  // ==========================================================
  // timer storage
  // ==========================================================
  logic [15:0] ten_pv_ff [NUM_TEN];
  logic [NUM_TEN-1:0] ten_done_ff;
  logic [NUM_TEN-1:0] ten_run_ff;
  logic [NUM_TEN-1:0] ten_in_ff;
  logic [NUM_TEN-1:0] ten_reload_ff;
  logic [15:0] ten_elapsed_ff [NUM_TEN];
  logic [15:0] one_pv_ff [NUM_ONE];
  logic [NUM_ONE-1:0] one_done_ff;
  logic [NUM_ONE-1:0] one_run_ff;
  logic [NUM_ONE-1:0] one_in_ff;
  logic [NUM_ONE-1:0] one_reload_ff;
  logic [15:0] one_elapsed_ff [NUM_ONE];

  // ==========================================================
  // selected timer view and next values
  // ==========================================================
  logic is_one;
  logic [3:0] one_idx;
  logic [15:0] cur_pv;
  logic cur_done;
  logic cur_run;
  logic cur_in;
  logic cur_reload;
  logic [15:0] cur_elapsed;
  logic [15:0] nxt_pv;
  logic nxt_run;
  logic nxt_done;
  logic nxt_bad;
  logic bcd_ok;
  logic keep;

  assign is_one = (res == RES_ONE);
  assign one_idx = timer_num[3:0];

  always_comb begin
    if (is_one) begin
      cur_pv = one_pv_ff[one_idx];
      cur_done = one_done_ff[one_idx];
      cur_run = one_run_ff[one_idx];
      cur_in = one_in_ff[one_idx];
      cur_reload = one_reload_ff[one_idx];
      cur_elapsed = one_elapsed_ff[one_idx];
    end else begin
      cur_pv = ten_pv_ff[timer_num];
      cur_done = ten_done_ff[timer_num];
      cur_run = ten_run_ff[timer_num];
      cur_in = ten_in_ff[timer_num];
      cur_reload = ten_reload_ff[timer_num];
      cur_elapsed = ten_elapsed_ff[timer_num];
    end
  end

  // nibble check for bcd coding
  always_comb begin
    bcd_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (preset_value[i*4 +: 4] > 4'h9) begin
        bcd_ok = 1'b0;
      end
    end
  end

  assign nxt_bad = bcd_mode && !bcd_ok;
  // jumped region or standby one-ms task: no refresh at all
  assign keep = jumped || (is_one && task_standby);
  // done only while timing or on force_set: zero preset with input low and no force_set stays clear
  assign nxt_done = force_set || (timer_in && !interlocked && !force_reset
                    && nxt_pv == ZERO_CNT);

  // execution of the selected timer
  always_comb begin
    nxt_pv = cur_pv;
    nxt_run = cur_run;
    if (force_set) begin
      nxt_pv = ZERO_CNT;
      nxt_run = 1'b0;
    end else if (force_reset || interlocked || !timer_in) begin
      nxt_pv = preset_value;
      nxt_run = 1'b0;
    end else if (!cur_in || cur_reload) begin
      nxt_pv = cur_reload ? preset_value : cur_pv;
      nxt_run = 1'b1;
      if (!cur_in) begin
        nxt_pv = preset_value;
      end
    end else if (cur_pv > cur_elapsed) begin
      nxt_pv = cur_pv - cur_elapsed;
    end else begin
      nxt_pv = ZERO_CNT;
    end
  end

  // ==========================================================
  // ten-ms bank
  // ==========================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_TEN; i++) begin
        ten_pv_ff[i] <= ZERO_CNT;
        ten_elapsed_ff[i] <= 16'h0;
      end
      ten_done_ff <= '0;
      ten_run_ff <= '0;
      ten_in_ff <= '0;
      ten_reload_ff <= '0;
    end else if (mode_change && !aux_word[HOLD_BIT]) begin
      for (int i = 0; i < NUM_TEN; i++) begin
        ten_pv_ff[i] <= ZERO_CNT;
        ten_elapsed_ff[i] <= 16'h0;
      end
      ten_done_ff <= '0;
      ten_run_ff <= '0;
      ten_in_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_TEN; i++) begin
        if (tick_ten && ten_run_ff[i] && ten_elapsed_ff[i] != 16'hffff) begin
          ten_elapsed_ff[i] <= ten_elapsed_ff[i] + 16'h1;
        end
      end
      if (clear_timer_op && !is_one) begin
        ten_pv_ff[timer_num] <= bcd_mode ? CLR_BCD : CLR_BIN;
        ten_done_ff[timer_num] <= 1'b0;
        ten_reload_ff[timer_num] <= 1'b1;
      end else if (pv_write && !is_one) begin
        ten_pv_ff[timer_num] <= pv_wdata;
        ten_elapsed_ff[timer_num] <= 16'h0;
      end else if (exec && !is_one && !keep) begin
        ten_pv_ff[timer_num] <= nxt_pv;
        ten_done_ff[timer_num] <= nxt_done;
        ten_run_ff[timer_num] <= nxt_run;
        ten_in_ff[timer_num] <= timer_in && !interlocked;
        ten_reload_ff[timer_num] <= 1'b0;
        ten_elapsed_ff[timer_num] <= 16'h0;
      end
    end
  end

  // ==========================================================
  // one-ms bank
  // ==========================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_ONE; i++) begin
        one_pv_ff[i] <= ZERO_CNT;
        one_elapsed_ff[i] <= 16'h0;
      end
      one_done_ff <= '0;
      one_run_ff <= '0;
      one_in_ff <= '0;
      one_reload_ff <= '0;
    end else if (mode_change && !aux_word[HOLD_BIT]) begin
      for (int i = 0; i < NUM_ONE; i++) begin
        one_pv_ff[i] <= ZERO_CNT;
        one_elapsed_ff[i] <= 16'h0;
      end
      one_done_ff <= '0;
      one_run_ff <= '0;
      one_in_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_ONE; i++) begin
        if (tick_one && one_run_ff[i] && one_elapsed_ff[i] != 16'hffff) begin
          one_elapsed_ff[i] <= one_elapsed_ff[i] + 16'h1;
        end
      end
      if (clear_timer_op && is_one) begin
        one_pv_ff[one_idx] <= bcd_mode ? CLR_BCD : CLR_BIN;
        one_done_ff[one_idx] <= 1'b0;
        one_reload_ff[one_idx] <= 1'b1;
      end else if (pv_write && is_one) begin
        one_pv_ff[one_idx] <= pv_wdata;
        one_elapsed_ff[one_idx] <= 16'h0;
      end else if (exec && is_one && !keep) begin
        one_pv_ff[one_idx] <= nxt_pv;
        one_done_ff[one_idx] <= nxt_done;
        one_run_ff[one_idx] <= nxt_run;
        one_in_ff[one_idx] <= timer_in && !interlocked;
        one_reload_ff[one_idx] <= 1'b0;
        one_elapsed_ff[one_idx] <= 16'h0;
      end
    end
  end

  // ==========================================================
  // result registers
  // ==========================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      present_count <= ZERO_CNT;
      done <= 1'b0;
      bad_bcd_flag <= 1'b0;
    end else if (exec) begin
      bad_bcd_flag <= nxt_bad;
      if (keep) begin
        present_count <= cur_pv;
        done <= cur_done;
      end else begin
        present_count <= nxt_pv;
        done <= nxt_done;
      end
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  // results of one execution
  a_bcd_error: assert property (@(posedge clk) disable iff (!resetn)
    exec |=> bad_bcd_flag == $past(bcd_mode && !bcd_ok))
    else $error("bcd error flag wrong");

  a_low_reload: assert property (@(posedge clk) disable iff (!resetn)
    exec && !timer_in && !force_set && !keep
    |=> present_count == $past(preset_value) && !done)
    else $error("low input did not reload");

  a_edge_start: assert property (@(posedge clk) disable iff (!resetn)
    exec && timer_in && !cur_in && !interlocked && !force_set && !force_reset && !keep
    |=> present_count == $past(preset_value) && done == ($past(preset_value) == ZERO_CNT))
    else $error("rising input did not start from preset");

  a_done_zero: assert property (@(posedge clk) disable iff (!resetn)
    exec && !keep && timer_in && !interlocked && !force_reset
    |=> done == (present_count == ZERO_CNT))
    else $error("done not matching zero count");

  a_force_set: assert property (@(posedge clk) disable iff (!resetn)
    exec && force_set && !keep |=> done && present_count == ZERO_CNT)
    else $error("force set failed");

  a_force_reset: assert property (@(posedge clk) disable iff (!resetn)
    exec && force_reset && !force_set && !keep
    |=> !done && present_count == $past(preset_value))
    else $error("force reset did not reload");

  a_interlock: assert property (@(posedge clk) disable iff (!resetn)
    exec && interlocked && !force_set && !keep
    |=> !done && present_count == $past(preset_value))
    else $error("interlock did not reload");

  a_jump_hold: assert property (@(posedge clk) disable iff (!resetn)
    exec && jumped && !clear_timer_op && !pv_write && !mode_change
    |=> present_count == $past(cur_pv) && done == $past(cur_done))
    else $error("jumped timer changed");

  a_no_wrap: assert property (@(posedge clk) disable iff (!resetn)
    exec && cur_pv == ZERO_CNT && timer_in && cur_in && !cur_reload && !interlocked
    && !force_reset && !keep |=> present_count == ZERO_CNT)
    else $error("count wrapped");

  a_clear_reload: assert property (@(posedge clk) disable iff (!resetn)
    exec && cur_reload && timer_in && !interlocked && !force_set && !force_reset && !keep
    |=> present_count == $past(preset_value))
    else $error("cleared timer did not reload");

  // timer storage
  a_done_store: assert property (@(posedge clk) disable iff (!resetn)
    exec && !is_one && !keep && !clear_timer_op && !pv_write && !mode_change
    |=> ten_done_ff[$past(timer_num)] == done)
    else $error("stored done differs from shown done");

  a_jump_store: assert property (@(posedge clk) disable iff (!resetn)
    exec && jumped && !is_one && !clear_timer_op && !pv_write && !mode_change
    |=> ten_pv_ff[$past(timer_num)] == $past(cur_pv))
    else $error("jumped timer storage changed");

  a_standby_hold: assert property (@(posedge clk) disable iff (!resetn)
    exec && is_one && task_standby && !clear_timer_op && !pv_write && !mode_change
    |=> one_pv_ff[$past(one_idx)] == $past(cur_pv))
    else $error("standby timer storage changed");

  a_pv_write: assert property (@(posedge clk) disable iff (!resetn)
    pv_write && !clear_timer_op && !mode_change && is_one
    |=> one_pv_ff[$past(one_idx)] == $past(pv_wdata))
    else $error("count write not stored");

  a_clear_op: assert property (@(posedge clk) disable iff (!resetn)
    clear_timer_op && !mode_change && !is_one
    |=> ten_pv_ff[$past(timer_num)] == ($past(bcd_mode) ? CLR_BCD : CLR_BIN)
    && !ten_done_ff[$past(timer_num)])
    else $error("clear op value wrong");

  a_clear_one: assert property (@(posedge clk) disable iff (!resetn)
    clear_timer_op && !mode_change && is_one
    |=> one_pv_ff[$past(one_idx)] == ($past(bcd_mode) ? CLR_BCD : CLR_BIN)
    && !one_done_ff[$past(one_idx)])
    else $error("one-ms clear op value wrong");

  // bank-wide mode change
  a_mode_clear: assert property (@(posedge clk) disable iff (!resetn)
    mode_change && !aux_word[HOLD_BIT]
    |=> ten_done_ff == '0 && one_done_ff == '0 && cur_pv == ZERO_CNT)
    else $error("mode change did not clear timers");

  a_mode_hold: assert property (@(posedge clk) disable iff (!resetn)
    mode_change && aux_word[HOLD_BIT] && !exec && !clear_timer_op && !pv_write
    |=> !$stable(timer_num) || !$stable(res) || cur_pv == $past(cur_pv))
    else $error("held timer changed on mode change");
endmodule // fast_decrementing_timer
`default_nettype wire

/* File: verif/scan_program.sv */
// controller program model issuing timer instructions
`timescale 1ns/1ps
`default_nettype none
module scan_program (
  // clock
  input wire logic clk,
  // instruction operands
  output var logic exec,
  output var fdt_pkg::res_t res,
  output var logic bcd_mode,
  output var logic [7:0] timer_num,
  output var logic timer_in,
  output var logic [15:0] preset_value
);
  import fdt_pkg::*;
  // ==========================================
  // idle operands
  initial begin
    exec = 1'b0;
    res = RES_TEN;
    bcd_mode = 1'b0;
    timer_num = 8'h00;
    timer_in = 1'b0;
    preset_value = 16'h0000;
  end
  // ==========================================
  // one timer instruction, one cycle long
  task automatic run(input res_t r, input logic b, input logic [7:0] n, input logic t,
                     input logic [15:0] s);
    @(posedge clk);
    res <= r;
    bcd_mode <= b;
    timer_num <= (r == RES_ONE) ? {4'h0, n[3:0]} : n;
    timer_in <= t;
    preset_value <= s;
    exec <= 1'b1;
    @(posedge clk);
    exec <= 1'b0;
  endtask
endmodule // scan_program
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the fast decrementing timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fdt_pkg::*;
  // ==========================================
  // signals
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic exec, bcd_mode, timer_in, done, bad_bcd_flag;
  res_t res;
  logic [7:0] timer_num;
  logic [15:0] preset_value, present_count, last;
  logic interlocked = 1'b0, jumped = 1'b0, task_standby = 1'b0;
  logic force_set = 1'b0, force_reset = 1'b0, clear_timer_op = 1'b0;
  logic mode_change = 1'b0, pv_write = 1'b0;
  logic [15:0] aux_word = 16'h0000, pv_wdata = 16'h0000;
  int num_errors = 0;
  int cmp_count = 0;
  int i;
  // ==========================================
  // instances
  fast_decrementing_timer #(.TEN_PERIOD(10), .ONE_PERIOD(1)) u_fast_decrementing_timer (
    .clk(clk), .resetn(resetn), .exec(exec), .res(res), .bcd_mode(bcd_mode),
    .timer_num(timer_num), .timer_in(timer_in), .preset_value(preset_value),
    .interlocked(interlocked), .jumped(jumped), .task_standby(task_standby),
    .force_set(force_set), .force_reset(force_reset), .clear_timer_op(clear_timer_op),
    .mode_change(mode_change), .aux_word(aux_word), .pv_write(pv_write),
    .pv_wdata(pv_wdata), .present_count(present_count), .done(done),
    .bad_bcd_flag(bad_bcd_flag)
  );
  scan_program u_scan_program (
    .clk(clk), .exec(exec), .res(res), .bcd_mode(bcd_mode), .timer_num(timer_num),
    .timer_in(timer_in), .preset_value(preset_value)
  );
  initial begin
    forever #5 clk = ~clk;
  end
  // ==========================================
  // access tasks
  task automatic op(input logic [4:0] c, input res_t r, input logic b, input logic [7:0] n,
                    input logic t, input logic [15:0] s);
    @(posedge clk);
    {interlocked, jumped, task_standby, force_set, force_reset} <= c;
    u_scan_program.run(r, b, n, t, s);
  endtask
  task automatic pulse(input logic [2:0] p, input logic [15:0] w);
    @(posedge clk);
    {clear_timer_op, mode_change, pv_write} <= p;
    aux_word <= w;
    pv_wdata <= w;
    @(posedge clk);
    {clear_timer_op, mode_change, pv_write} <= 3'b000;
  endtask
  task automatic chk(input logic [15:0] lo, input logic [15:0] hi, input logic d,
                     input logic e);
    #1;
    cmp_count++;
    if ((present_count >= lo && present_count <= hi) !== 1'b1 || done !== d ||
        bad_bcd_flag !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t count=%h done=%b err=%b", $time, present_count, done,
               bad_bcd_flag);
    end
  endtask
  task automatic final_report;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report;
  end
  // ==========================================
  // tests
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    chk(16'h0000, 16'h0000, 1'b0, 1'b0);
    op(5'h00, RES_TEN, 1'b1, 8'hff, 1'b0, 16'h12a4);
    chk(16'h0000, 16'hffff, 1'b0, 1'b1);
    op(5'h00, RES_TEN, 1'b1, 8'hff, 1'b0, 16'h9999);
    chk(16'h9999, 16'h9999, 1'b0, 1'b0);
    op(5'h00, RES_TEN, 1'b0, 8'hff, 1'b0, 16'hffff);
    chk(16'hffff, 16'hffff, 1'b0, 1'b0);
    op(5'h00, RES_TEN, 1'b0, 8'hff, 1'b1, 16'h0064);
    chk(16'h0063, 16'h0064, 1'b0, 1'b0);
    repeat (48) @(posedge clk);
    op(5'h00, RES_TEN, 1'b0, 8'hff, 1'b1, 16'h0064);
    chk(16'h005d, 16'h0060, 1'b0, 1'b0);
    last = present_count;
    repeat (30) @(posedge clk);
    op(5'h08, RES_TEN, 1'b0, 8'hff, 1'b1, 16'h0064);
    chk(last, last, 1'b0, 1'b0);
    op(5'h10, RES_TEN, 1'b0, 8'hff, 1'b1, 16'h0064);
    chk(16'h0064, 16'h0064, 1'b0, 1'b0);
    op(5'h00, RES_ONE, 1'b0, 8'h0f, 1'b0, 16'h001e);
    chk(16'h001e, 16'h001e, 1'b0, 1'b0);
    op(5'h00, RES_ONE, 1'b0, 8'h0f, 1'b1, 16'h001e);
    chk(16'h001d, 16'h001e, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    op(5'h00, RES_ONE, 1'b0, 8'h0f, 1'b1, 16'h001e);
    chk(16'h0012, 16'h0015, 1'b0, 1'b0);
    last = present_count;
    repeat (8) @(posedge clk);
    op(5'h04, RES_ONE, 1'b0, 8'h0f, 1'b1, 16'h001e);
    chk(last, last, 1'b0, 1'b0);
    repeat (40) @(posedge clk);
    op(5'h00, RES_ONE, 1'b0, 8'h0f, 1'b1, 16'h001e);
    chk(16'h0000, 16'h0000, 1'b1, 1'b0);
    repeat (5) @(posedge clk);
    op(5'h00, RES_ONE, 1'b0, 8'h0f, 1'b1, 16'h001e);
    chk(16'h0000, 16'h0000, 1'b1, 1'b0);
    pulse(3'b001, 16'h0005);
    op(5'h00, RES_ONE, 1'b0, 8'h0f, 1'b1, 16'h001e);
    chk(16'h0002, 16'h0005, 1'b0, 1'b0);
    op(5'h02, RES_ONE, 1'b0, 8'h0f, 1'b1, 16'h001e);
    chk(16'h0000, 16'h0000, 1'b1, 1'b0);
    op(5'h01, RES_ONE, 1'b0, 8'h0f, 1'b1, 16'h001e);
    chk(16'h001e, 16'h001e, 1'b0, 1'b0);
    for (i = 0; i < 2; i++) begin
      op(5'h01, i ? RES_ONE : RES_TEN, i[0], 8'h0f, 1'b1, 16'h0030);
      pulse(3'b100, 16'h0000);
      op(5'h08, i ? RES_ONE : RES_TEN, i[0], 8'h0f, 1'b1, 16'h0030);
      chk(i ? 16'h9999 : 16'hffff, i ? 16'h9999 : 16'hffff, 1'b0, 1'b0);
      op(5'h00, i ? RES_ONE : RES_TEN, i[0], 8'h0f, 1'b1, 16'h0030);
      chk(16'h002e, 16'h0030, 1'b0, 1'b0);
    end
    for (i = 0; i < 2; i++) begin
      op(5'h00, RES_ONE, 1'b0, 8'h0f, 1'b0, 16'h0030);
      pulse(3'b010, i ? 16'h1000 : 16'h0000);
      op(5'h08, RES_ONE, 1'b0, 8'h0f, 1'b0, 16'h0030);
      chk(i ? 16'h0030 : 16'h0000, i ? 16'h0030 : 16'h0000, 1'b0, 1'b0);
    end
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chk(16'h0000, 16'h0000, 1'b0, 1'b0);
    op(5'h08, RES_ONE, 1'b0, 8'h0f, 1'b1, 16'h0030);
    chk(16'h0000, 16'h0000, 1'b0, 1'b0);
    final_report;
  end
endmodule // tb
`default_nettype wire
